// *** verilog/color_pixel_pipeline_regs.svh ***
// Offsets, field positions, reset values and fixed constants of the colour pixel pipeline
`ifndef COLOR_PIXEL_PIPELINE_REGS_SVH
`define COLOR_PIXEL_PIPELINE_REGS_SVH

// Register byte offsets
`define CPP_CTRL_OFS 4'h0
`define CPP_STATUS_OFS 4'h4

// Control register fields
`define CPP_SHARP_LSB 0
`define CPP_SHARP_MSB 1
`define CPP_CCM_EN_BIT 2
`define CPP_MIRROR_BIT 3
`define CPP_SUB_EN_BIT 4
`define CPP_CODING_LSB 5
`define CPP_CODING_MSB 7
`define CPP_MODE_LSB 8
`define CPP_MODE_MSB 10
`define CPP_CTRL_MASK 32'h0000_07ff
`define CPP_CTRL_RST 32'h0000_0044

// Colour codings and scalable mode that force raw transfer
`define CPP_CODING_MONO_EIGHT_BIT_CODING 3'h0
`define CPP_CODING_RAW_EIGHT_BIT_CODING 3'h1
`define CPP_MODE_RAW 3'h1

// Line store depth and column index width
`define CPP_LINE_MAX 2048
`define CPP_COL_W 11

// Fixed factory correction matrix, Q8, each row sums to 256
`define CPP_C_RR 12'sh140
`define CPP_C_RG 12'shfd0
`define CPP_C_RB 12'shff0
`define CPP_C_GR 12'shfe0
`define CPP_C_GG 12'sh140
`define CPP_C_GB 12'shfe0
`define CPP_C_BR 12'shff0
`define CPP_C_BG 12'shfd0
`define CPP_C_BB 12'sh140
`define CPP_ROUND 23'sh000080

`endif

// *** verilog/color_pixel_pipeline_pkg.sv ***
// Types shared by the colour pixel pipeline
package color_pixel_pipeline_pkg;

  typedef enum logic [1:0] {COL_R, COL_G, COL_B} col_t;

  typedef struct packed {
    logic [1:0] sharp;
    logic ccm_en;
    logic mirror;
    logic sub_en;
    logic raw;
  } cfg_t;

  typedef struct packed {
    logic sof;
    logic sol;
    logic [7:0] data;
  } in_pix_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_t;

  typedef struct packed {
    logic sof;
    logic sol;
    cfg_t cfg;
    rgb_t pix;
  } stage_t;

  typedef struct packed {
    logic sof;
    logic sol;
    logic raw;
    rgb_t pix;
  } out_pix_t;

endpackage

// *** verilog/color_pixel_pipeline.sv ***
// Colour pixel pipeline: demosaic, sharpen, colour correction, raw bypass, sub-sampling
//
// Notes on behaviour
// - Every output pixel outside raw transfer gets red, green and blue computed from its own line and the previously kept line only.
// - Red and blue come straight from the nearest samples, green is the mean of two greens.
// - Output width equals input width unless sub-sampling is on; the left column sees zeros and shows a coloured border.
// - Correction acts on demosaiced RGB, after interpolation and before the YUV stage.
// - Each corrected channel is a weighted sum of input red, green and blue.
// - Correction coefficients are fixed constants that no register write can reach.
// - With the correction enable cleared and sharpness off, RGB passes unmodified.
// - Raw transfer bypasses demosaicing and correction and sends the Bayer sample.
// - Mono coding, raw coding or scalable mode one selects raw; mono disables correction.
// - Sharpness has off, step one and step two, a growing horizontal boost on green only.
// - Sub-sampling keeps two of every four columns and rows, keeping the Bayer pattern.
// - Sub-sampling drops pixels without summing, so brightness is unchanged.
// - Sub-sampling only shrinks output data volume; input rate is untouched.
// - With mirroring on the Bayer phase is taken as green-red-blue-green.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
`include "color_pixel_pipeline_regs.svh"

module color_pixel_pipeline (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic in_valid,
  input wire color_pixel_pipeline_pkg::in_pix_t in_pix,
  output logic in_ready,
  output logic out_valid,
  output color_pixel_pipeline_pkg::out_pix_t out_pix,
  input wire logic out_ready
);
  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Bayer colour at a row and column parity
  function automatic color_pixel_pipeline_pkg::col_t color_of(input logic rowp,
      input logic colp, input logic mirror);
    color_pixel_pipeline_pkg::col_t c;
    c = color_pixel_pipeline_pkg::COL_G;
    if (!mirror) begin
      if (!rowp && !colp) c = color_pixel_pipeline_pkg::COL_R;
      else if (rowp && colp) c = color_pixel_pipeline_pkg::COL_B;
    end else begin
      if (!rowp && colp) c = color_pixel_pipeline_pkg::COL_R;
      else if (rowp && !colp) c = color_pixel_pipeline_pkg::COL_B;
    end
    return c;
  endfunction
  // Mean of two samples
  function automatic logic [7:0] mean2(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8:1];
  endfunction
  // Clip a signed value to the 8-bit pixel range
  function automatic logic [7:0] sat8(input logic signed [22:0] v);
    logic [7:0] o;
    o = v[7:0];
    if (v < 23'sh000000) o = 8'h00;
    else if (v > 23'sh0000ff) o = 8'hff;
    return o;
  endfunction
  // One corrected channel: weighted sum, rounding, saturation
  function automatic logic [7:0] ccm_ch(input color_pixel_pipeline_pkg::rgb_t p,
      input logic signed [11:0] cr, input logic signed [11:0] cg,
      input logic signed [11:0] cb);
    logic signed [22:0] s;
    s = 23'(cr * $signed({1'b0, p.r})) + 23'(cg * $signed({1'b0, p.g}))
      + 23'(cb * $signed({1'b0, p.b}));
    s = (s + `CPP_ROUND) >>> 8;
    return sat8(s);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [31:0] ctrl_ff;
  logic [15:0] frame_cnt_ff;
  color_pixel_pipeline_pkg::cfg_t cfg_ff;
  color_pixel_pipeline_pkg::cfg_t ctrl_cfg;
  color_pixel_pipeline_pkg::cfg_t cur_cfg;
  logic [2:0] coding;
  logic [2:0] vmode;
  logic in_ready_ff;
  logic in_take;
  // Control register write; only the control fields are held
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= `CPP_CTRL_RST;
    end else if (wr && addr == `CPP_CTRL_OFS) begin
      ctrl_ff <= wdata & `CPP_CTRL_MASK;
    end
  end
  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (rd && addr == `CPP_CTRL_OFS) begin
      rdata <= ctrl_ff;
    end else if (rd && addr == `CPP_STATUS_OFS) begin
      rdata <= {frame_cnt_ff, 10'h000, cfg_ff};
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
  // Decode control fields into a configuration
  assign coding = ctrl_ff[`CPP_CODING_MSB:`CPP_CODING_LSB];
  assign vmode = ctrl_ff[`CPP_MODE_MSB:`CPP_MODE_LSB];
  always_comb begin
    ctrl_cfg.sharp = ctrl_ff[`CPP_SHARP_MSB:`CPP_SHARP_LSB];
    ctrl_cfg.mirror = ctrl_ff[`CPP_MIRROR_BIT];
    ctrl_cfg.sub_en = ctrl_ff[`CPP_SUB_EN_BIT];
    ctrl_cfg.raw = (coding == `CPP_CODING_MONO_EIGHT_BIT_CODING) || (coding == `CPP_CODING_RAW_EIGHT_BIT_CODING)
      || (vmode == `CPP_MODE_RAW);
    ctrl_cfg.ccm_en = ctrl_ff[`CPP_CCM_EN_BIT] && (coding != `CPP_CODING_MONO_EIGHT_BIT_CODING);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Frame configuration and input position
  assign in_take = in_valid && in_ready_ff;
  // The frame's first pixel already sees the new settings
  assign cur_cfg = (in_take && in_pix.sof) ? ctrl_cfg : cfg_ff;
  // Active settings are captured only at a frame start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff <= '0;
      frame_cnt_ff <= 16'h0000;
    end else if (in_take && in_pix.sof) begin
      cfg_ff <= ctrl_cfg;
      frame_cnt_ff <= frame_cnt_ff + 16'h0001;
    end
  end
  logic [1:0] xph_ff;
  logic [1:0] yph_ff;
  logic [1:0] xph;
  logic [1:0] yph;
  logic keep;
  // Input column and row phase for sub-sampling
  assign xph = in_pix.sol || in_pix.sof ? 2'h0 : xph_ff;
  assign yph = in_pix.sof ? 2'h0 : (in_pix.sol ? yph_ff + 2'h1 : yph_ff);
  // Keep phases 0 and 1 of every four so pairs of Bayer colours survive
  assign keep = !cur_cfg.sub_en || (!xph[1] && !yph[1]);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xph_ff <= 2'h0;
      yph_ff <= 2'h0;
    end else if (in_take) begin
      xph_ff <= xph + 2'h1;
      yph_ff <= yph;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Demosaic stage
  logic [7:0] line_mem [0:`CPP_LINE_MAX-1];
  logic [`CPP_COL_W-1:0] kx_ff;
  logic ky_ff;
  logic [`CPP_COL_W-1:0] kx;
  logic ky;
  logic [7:0] cl_ff;
  logic [7:0] al_ff;
  logic [7:0] above;
  logic [7:0] cl;
  logic [7:0] al;
  logic line_start;
  logic kept;
  color_pixel_pipeline_pkg::col_t c_col;
  color_pixel_pipeline_pkg::col_t a_col;
  color_pixel_pipeline_pkg::rgb_t dem;
  assign kept = in_take && keep;
  assign line_start = in_pix.sol || in_pix.sof;
  assign kx = line_start ? '0 : kx_ff;
  assign ky = in_pix.sof ? 1'b0 : (in_pix.sol ? !ky_ff : ky_ff);
  assign above = line_mem[kx];
  // The left column has no left neighbours and uses zeros
  assign cl = line_start ? 8'h00 : cl_ff;
  assign al = line_start ? 8'h00 : al_ff;
  assign c_col = color_of(ky, kx[0], cur_cfg.mirror);
  assign a_col = color_of(!ky, kx[0], cur_cfg.mirror);
  // Two-line window: current, above, left, above-left
  always_comb begin
    dem.r = 8'h00;
    dem.g = 8'h00;
    dem.b = 8'h00;
    if (c_col == color_pixel_pipeline_pkg::COL_G) begin
      dem.g = mean2(in_pix.data, al);
      dem.r = (a_col == color_pixel_pipeline_pkg::COL_R) ? above : cl;
      dem.b = (a_col == color_pixel_pipeline_pkg::COL_R) ? cl : above;
    end else begin
      dem.g = mean2(above, cl);
      dem.r = (c_col == color_pixel_pipeline_pkg::COL_R) ? in_pix.data : al;
      dem.b = (c_col == color_pixel_pipeline_pkg::COL_R) ? al : in_pix.data;
    end
  end
  // Line store and window update for kept pixels only
  always_ff @(posedge clk) begin
    if (kept) begin
      line_mem[kx] <= in_pix.data;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kx_ff <= '0;
      ky_ff <= 1'b0;
      cl_ff <= 8'h00;
      al_ff <= 8'h00;
    end else if (kept) begin
      kx_ff <= kx + `CPP_COL_W'(1);
      ky_ff <= ky;
      cl_ff <= in_pix.data;
      al_ff <= above;
    end
  end
  color_pixel_pipeline_pkg::stage_t s1_ff;
  logic s1_vld_ff;
  logic en;
  // Dropped pixels leave a bubble; the input is never throttled for them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_vld_ff <= 1'b0;
      s1_ff <= '0;
    end else if (en) begin
      s1_vld_ff <= kept;
      s1_ff.sof <= in_pix.sof;
      s1_ff.sol <= line_start;
      s1_ff.cfg <= cur_cfg;
      if (cur_cfg.raw) begin
        s1_ff.pix <= {in_pix.data, in_pix.data, in_pix.data};
      end else begin
        s1_ff.pix <= dem;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sharpening and colour correction stage
  logic [7:0] gprev_ff;
  logic signed [22:0] gdiff;
  logic signed [22:0] gboost;
  color_pixel_pipeline_pkg::rgb_t shp;
  color_pixel_pipeline_pkg::rgb_t cor;
  // Horizontal high pass on green, stronger at step two
  assign gdiff = $signed({15'h0000, s1_ff.pix.g})
    - $signed({15'h0000, s1_ff.sol ? s1_ff.pix.g : gprev_ff});
  always_comb begin
    gboost = 23'sh000000;
    case (s1_ff.cfg.sharp)
      2'h1: gboost = gdiff >>> 2;
      2'h2: gboost = gdiff >>> 1;
      default: gboost = 23'sh000000;
    endcase
    shp = s1_ff.pix;
    shp.g = sat8($signed({15'h0000, s1_ff.pix.g}) + gboost);
  end
  // Fixed matrix on demosaiced data ahead of the YUV stage
  always_comb begin
    cor.r = ccm_ch(shp, `CPP_C_RR, `CPP_C_RG, `CPP_C_RB);
    cor.g = ccm_ch(shp, `CPP_C_GR, `CPP_C_GG, `CPP_C_GB);
    cor.b = ccm_ch(shp, `CPP_C_BR, `CPP_C_BG, `CPP_C_BB);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gprev_ff <= 8'h00;
    end else if (en && s1_vld_ff) begin
      gprev_ff <= s1_ff.pix.g;
    end
  end
  color_pixel_pipeline_pkg::out_pix_t s2_ff;
  logic s2_vld_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s2_vld_ff <= 1'b0;
      s2_ff <= '0;
    end else if (en) begin
      s2_vld_ff <= s1_vld_ff;
      s2_ff.sof <= s1_ff.sof;
      s2_ff.sol <= s1_ff.sol;
      s2_ff.raw <= s1_ff.cfg.raw;
      if (s1_ff.cfg.raw) begin
        s2_ff.pix <= s1_ff.pix;
      end else if (s1_ff.cfg.ccm_en) begin
        s2_ff.pix <= cor;
      end else begin
        s2_ff.pix <= shp;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer
  color_pixel_pipeline_pkg::out_pix_t buf1_ff;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic push;
  logic pop;
  assign en = in_ready_ff;
  assign push = en && s2_vld_ff;
  assign pop = out_valid && out_ready;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) nxt_cnt = cnt_ff + 2'h1;
    else if (pop && !push) nxt_cnt = cnt_ff - 2'h1;
  end
  // Head entry drives the outputs; the pipeline stalls while both are full
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 2'h0;
      in_ready_ff <= 1'b1;
      out_valid <= 1'b0;
      out_pix <= '0;
      buf1_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      in_ready_ff <= (nxt_cnt != 2'h2);
      out_valid <= (nxt_cnt != 2'h0);
      if (push && (cnt_ff == 2'h1) && !pop) begin
        buf1_ff <= s2_ff;
      end
      if (pop && cnt_ff == 2'h2) begin
        out_pix <= buf1_ff;
        if (push) buf1_ff <= s2_ff;
      end else if ((pop || cnt_ff == 2'h0) && push) begin
        out_pix <= s2_ff;
      end
    end
  end
  assign in_ready = in_ready_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  raw_bypass_a: assert property (@(posedge clk) disable iff (!nrst)
    s1_vld_ff && s1_ff.cfg.raw |-> s1_ff.pix.r == s1_ff.pix.g && s1_ff.pix.g == s1_ff.pix.b)
    else $error("raw pixel was colour processed");
  sub_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    in_take && cur_cfg.sub_en && (xph[1] || yph[1]) |=> !s1_vld_ff)
    else $error("sub-sampled pixel was not dropped");
  full_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    in_take && !cur_cfg.sub_en |=> s1_vld_ff)
    else $error("pixel lost at full resolution");
  cfg_frame_a: assert property (@(posedge clk) disable iff (!nrst)
    !(in_take && in_pix.sof) |=> cfg_ff == $past(cfg_ff))
    else $error("settings changed inside a frame");
  sharp_off_a: assert property (@(posedge clk) disable iff (!nrst)
    en && s1_vld_ff && !s1_ff.cfg.raw && !s1_ff.cfg.ccm_en && s1_ff.cfg.sharp == 2'h0
    |=> s2_ff.pix == $past(s1_ff.pix))
    else $error("pixel altered with correction and sharpness off");
  ccm_white_a: assert property (@(posedge clk) disable iff (!nrst)
    en && s1_vld_ff && !s1_ff.cfg.raw && s1_ff.cfg.ccm_en && s1_ff.cfg.sharp == 2'h0
    && s1_ff.pix == 24'hffffff |=> s2_ff.pix == 24'hffffff)
    else $error("white not kept by correction");
  mirror_green_a: assert property (@(posedge clk) disable iff (!nrst)
    in_take && keep && !cur_cfg.raw && cur_cfg.mirror && !ky && !kx[0]
    |=> s1_ff.pix.g == mean2($past(in_pix.data), $past(al)))
    else $error("mirrored phase not green at origin");
  buf_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && !out_ready |=> out_valid && $stable(out_pix))
    else $error("stalled output word changed or lost");
endmodule

// *** bench/pixel_sink.sv ***
// Stand-in for the video formatter that takes the pipeline's output words
`timescale 1ns/10ps
module pixel_sink (
  input wire logic clk,
  input wire logic nrst,
  input wire logic block,
  output logic out_ready
);
  // Ready drops at random and for whole blocked stretches, so the buffer fills
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !block && ($urandom % 4 != 0);
    end
  end
endmodule

// *** bench/test_color_pixel_pipeline.sv ***
// Self-checking bench: random frames in ten control settings, checked word by word at the output
`timescale 1ns/10ps
`include "color_pixel_pipeline_regs.svh"
module test_color_pixel_pipeline;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic in_valid = 1'b0;
  color_pixel_pipeline_pkg::in_pix_t in_pix = '0;
  logic [31:0] rdata;
  logic in_ready, out_valid, out_ready, block;
  logic seen_full = 1'b0;
  color_pixel_pipeline_pkg::out_pix_t out_pix;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int frames = 0;
  logic [7:0] img [0:7][0:15];
  logic [26:0] exq [$];
  bit chq [$];

  color_pixel_pipeline color_pixel_pipeline_inst (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .in_valid(in_valid), .in_pix(in_pix),
    .in_ready(in_ready), .out_valid(out_valid), .out_pix(out_pix), .out_ready(out_ready));
  pixel_sink pixel_sink_inst (.clk(clk), .nrst(nrst), .block(block), .out_ready(out_ready));

  // Clock, periodic long stall of the sink, and hang limit
  always #2.5 clk = ~clk;
  assign block = cyc[8:5] == 4'h3;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!in_ready) seen_full <= 1'b1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic int sat(int v);
    return v < 0 ? 0 : (v > 255 ? 255 : v);
  endfunction

  function automatic bit is_raw(logic [31:0] c);
    return c[7:5] < 3'h2 || c[10:8] == `CPP_MODE_RAW;
  endfunction

  // Two-line 2x2 window holds one red, one blue and two greens
  function automatic void demo(int y, int x, bit m, output int r, output int g, output int b);
    int v, q, rp;
    r = 0;
    g = 0;
    b = 0;
    for (int k = 0; k < 4; k++) begin
      rp = (y - k % 2) & 1;
      q = ((x - k / 2) & 1) ^ m;
      v = (x == 0 && k > 1) ? 0 : img[y - k % 2][x - k / 2];
      if (rp == 0 && q == 0) r = v;
      else if (rp == 1 && q == 1) b = v;
      else g += v;
    end
    g = g / 2;
  endfunction

  function automatic logic [26:0] expect_pix(int y, int x, logic [31:0] c, bit f, bit l);
    int r, g, b, r0, gp, b0, sh;
    if (is_raw(c)) return {f, l, 1'b1, {3{img[y][x]}}};
    demo(y, x, c[3], r, g, b);
    sh = c[1:0] == 2'h1 ? 2 : (c[1:0] == 2'h2 ? 1 : 0);
    if (sh > 0 && x > 0) begin
      demo(y, x - 1, c[3], r0, gp, b0);
      g = sat(g + ((g - gp) >>> sh));
    end
    if (c[2]) begin
      r0 = sat((`CPP_C_RR * r + `CPP_C_RG * g + `CPP_C_RB * b + 128) >>> 8);
      gp = sat((`CPP_C_GR * r + `CPP_C_GG * g + `CPP_C_GB * b + 128) >>> 8);
      b = sat((`CPP_C_BR * r + `CPP_C_BG * g + `CPP_C_BB * b + 128) >>> 8);
      r = r0;
      g = gp;
    end
    return {f, l, 1'b0, r[7:0], g[7:0], b[7:0]};
  endfunction

  // Output monitor compares each accepted word flagged in chq with the next expected one
  always @(posedge clk) begin
    if (nrst && out_valid && out_ready) begin
      if (exq.size() == 0) begin
        check("extra_word", 32'h1, 32'h0);
      end else begin
        if (chq[0]) check("out_pix", 32'(out_pix), 32'(exq[0]));
        void'(exq.pop_front());
        void'(chq.pop_front());
      end
    end
  end

  // One frame with random samples and random gaps; the control register is rewritten halfway
  task automatic run_frame(logic [31:0] c, int w, int h);
    bit sub;
    bit first;
    logic [31:0] st;
    sub = c[4];
    first = 1'b1;
    wr_reg(`CPP_CTRL_OFS, c);
    for (int y = 0; y < h; y++) begin
      for (int x = 0; x < w; x++) begin
        // Corner case: white rows under correction reach the white-point check
        img[y][x] = (c == 32'h044 && y > 1) ? 8'hff : 8'($urandom);
        if (!sub || (x % 4 < 2 && y % 4 < 2)) begin
          exq.push_back(expect_pix(y, x, c, first, x == 0));
          chq.push_back(is_raw(c) || y > 0);
          first = 1'b0;
        end
        if ($urandom % 4 == 0) begin
          in_valid <= 1'b0;
          @(posedge clk);
        end
        in_valid <= 1'b1;
        in_pix <= {x == 0 && y == 0, x == 0, img[y][x]};
        if (y * w + x == w * h / 2) begin
          addr <= `CPP_CTRL_OFS;
          wdata <= c ^ 32'h1f;
          wr <= 1'b1;
        end
        @(posedge clk);
        wr <= 1'b0;
        while (!in_ready) @(posedge clk);
      end
    end
    in_valid <= 1'b0;
    for (int i = 0; i < 300 && exq.size() > 0; i++) @(posedge clk);
    check("words_left", exq.size(), 0);
    exq.delete();
    chq.delete();
    frames++;
    rd_reg(`CPP_STATUS_OFS, st);
    check("status", st & 32'hffff000f, {frames[15:0], 12'h0,
      c[2] && c[7:5] != `CPP_CODING_MONO_EIGHT_BIT_CODING, c[3], c[4], is_raw(c)});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [31:0] cases [10];
    // Raw frame first, so the line store holds real samples before processed frames
    cases = '{32'h020, 32'h040, 32'h048, 32'h041, 32'h042, 32'h043, 32'h044, 32'h004,
      32'h140, 32'h030};
    void'($urandom(32'h2fc8));
    repeat (5) @(posedge clk);
    check("rdata_rst", rdata, 32'h0);
    check("in_ready_rst", 32'(in_ready), 32'h1);
    check("out_valid_rst", 32'(out_valid), 32'h0);
    nrst <= 1'b1;
    rd_reg(`CPP_CTRL_OFS, v);
    check("ctrl_rst", v, `CPP_CTRL_RST);
    rd_reg(4'h8, v);
    check("unmapped", v, 32'h0);
    wr_reg(`CPP_CTRL_OFS, 32'hffffffff);
    rd_reg(`CPP_CTRL_OFS, v);
    check("ctrl_mask", v, `CPP_CTRL_MASK);
    foreach (cases[i]) begin
      run_frame(cases[i], cases[i] == 32'h030 ? 8 : 16, cases[i] == 32'h030 ? 8 : 4);
    end
    check("stall_seen", 32'(seen_full), 32'h1);
    end_sim();
  end
endmodule
